// ### rtl/pmsfe_pkg.sv
/*
 * pmsfe_pkg: constants, types and state for the system function enable register block.
 * assumes: one 50 MHz clock, registers reached over the serial two-wire port only.
 */
package pmsfe_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    localparam int CLK_PERIOD_NS = 20;

    // serial port addressing
    localparam logic [6:0] PMSFE_DEV_ADDR = 7'h12;
    localparam logic [7:0] PMSFE_SFE_OFFSET = 8'h10;
    localparam logic [7:0] PMSFE_UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions of system_function_enable
    localparam int SFE_SLEEP_BIT = 7;
    localparam int SFE_RTC_BIT = 6;
    localparam int SFE_CHARGE_BIT = 5;
    localparam int SFE_COMPARATOR_BIT = 4;
    localparam int SFE_TIMER_BIT = 3;
    localparam int SFE_EXPIRY_PD_BIT = 2;
    localparam int SFE_EXPIRY_RST_BIT = 1;
    localparam int SFE_COLD_PD_BIT = 0;

    // value after reset; bit 6 is then reloaded from the battery-held copy
    localparam logic [7:0] SFE_RESET_VALUE = 8'h00;
    // bits that the nonvolatile store restores (sleep, charger and rtc are not among them)
    localparam logic [7:0] SFE_NV_MASK = 8'h1F;

    // cycles after reset release before the synchronised battery copy is valid
    localparam logic [1:0] PMSFE_SETTLE_CYCLES = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // serial port states
    typedef enum logic [3:0] {
        PMSFE_IDLE = 4'h0,
        PMSFE_ADDR = 4'h1,
        PMSFE_ADDR_ACK = 4'h2,
        PMSFE_PTR = 4'h3,
        PMSFE_PTR_ACK = 4'h4,
        PMSFE_WDATA = 4'h5,
        PMSFE_WDATA_ACK = 4'h6,
        PMSFE_RDATA = 4'h7,
        PMSFE_RDATA_ACK = 4'h8
    } pmsfe_fsm_type;

    // synchronised pin levels
    typedef struct packed {
        logic scl;
        logic sda;
        logic cold_n;
        logic rtc_kept;
    } pmsfe_pins_type;

    // all state of the top module
    typedef struct packed {
        pmsfe_fsm_type fsm;
        logic [2:0] bit_cnt;
        logic byte_full;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic master_ack;
        logic sda_oe;
        logic scl_prev;
        logic sda_prev;
        logic cold_prev;
        logic [1:0] settle;
        logic [7:0] ctrl;
        logic powerdown_req;
        logic reset_req;
    } pmsfe_state_type;

endpackage

// ### rtl/pmsfe_sync.sv
/*
 * pmsfe_sync: two flip-flop synchroniser, one per bit.
 * assumes: inputs are asynchronous levels; reset level is a constant.
 */
`timescale 1ns/10ps
module pmsfe_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // first stage is read only by the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1_reg;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stage1_reg <= IDLE_LEVEL[i];
                    sync_out[i] <= IDLE_LEVEL[i];
                end else begin
                    stage1_reg <= async_in[i];
                    sync_out[i] <= stage1_reg;
                end
            end
        end
    endgenerate

endmodule

// ### rtl/pmsfe_top.sv
/*
 * pmsfe_top: system function enable register with its two-wire slave port and the
 * actions taken on supervisor expiry and on the cold-reset pin.
 * assumes: SCL/SDA, cold-reset pin and battery copy are asynchronous pins; the
 * expiry and restore strobes come from logic on CLK.
 */
// What this block does
// [RL1] bit 7 enters or leaves sleep
// [RL2] bit 6 enables clock, kept by battery
// [RL3] bit 5 enables coin-cell charger, not restored
// [RL4] bit 4 enables backup-supply comparator
// [RL5] bit 3 lets the supervisor timer run
// [RL6] bit 2: expiry starts power-down
// [RL7] bit 1: expiry produces a reset
// [RL8] bit 0: cold-reset pin causes power-down
// [RL9] all bits read back last written value
`timescale 1ns/10ps
module pmsfe_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // two-wire serial port, open drain data
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // pins and strobes from the rest of the device
    input wire logic COLD_RESET_INPUT_N,
    input wire logic SUPERVISOR_EXPIRED,
    input wire logic RTC_ENABLE_KEPT,
    input wire logic NV_LOAD,
    input wire logic [7:0] NV_DATA,
    // controls
    output logic SLEEP_ENABLE,
    output logic RTC_ENABLE,
    output logic BACKUP_CELL_CHARGE_ENABLE,
    output logic BACKUP_SUPPLY_COMPARATOR_ENABLE,
    output logic SUPERVISOR_TIMER_ENABLE,
    output logic [7:0] SYSTEM_FUNCTION_ENABLE,
    // actions, one-cycle pulses
    output logic POWERDOWN_REQ,
    output logic RESET_REQ
);

    ////////////////////////////////////////////////////////////////////////////////
    pmsfe_pkg::pmsfe_pins_type pins;
    pmsfe_pkg::pmsfe_state_type state_reg;
    pmsfe_pkg::pmsfe_state_type state_next;
    logic [3:0] pins_raw;

    assign pins_raw = {SCL_IN, SDA_IN, COLD_RESET_INPUT_N, RTC_ENABLE_KEPT};

    pmsfe_sync #(
        .WIDTH(4),
        .IDLE_LEVEL(4'hE)
    ) u_sync (
        .clk(CLK),
        .resetn(RESETN),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] read_value;

    assign scl_rise = pins.scl && !state_reg.scl_prev;
    assign scl_fall = !pins.scl && state_reg.scl_prev;
    assign start_seen = pins.scl && state_reg.scl_prev && state_reg.sda_prev && !pins.sda;
    assign stop_seen = pins.scl && state_reg.scl_prev && !state_reg.sda_prev && pins.sda;
    // only one register is mapped; other pointers read as zero
    assign read_value = (state_reg.ptr == pmsfe_pkg::PMSFE_SFE_OFFSET) ?
                        state_reg.ctrl : pmsfe_pkg::PMSFE_UNMAPPED_READ; // RL9

    always_comb begin
        state_next = state_reg;
        state_next.scl_prev = pins.scl;
        state_next.sda_prev = pins.sda;
        state_next.cold_prev = pins.cold_n;
        state_next.powerdown_req = 1'b0;
        state_next.reset_req = 1'b0;

        ////////////////////////////////////////////////////////////////////////////
        // restore paths: battery copy once after reset, nonvolatile copy on strobe
        if (state_reg.settle != pmsfe_pkg::PMSFE_SETTLE_CYCLES) begin
            state_next.settle = state_reg.settle + 2'h1;
            if (state_reg.settle == pmsfe_pkg::PMSFE_SETTLE_CYCLES - 2'h1) begin
                state_next.ctrl[pmsfe_pkg::SFE_RTC_BIT] = pins.rtc_kept; // RL2
            end
        end
        if (NV_LOAD) begin
            // sleep, charger and rtc bits are left as they are
            // built on state_next so a battery reload in the same cycle is not lost
            state_next.ctrl = (state_next.ctrl & ~pmsfe_pkg::SFE_NV_MASK) |
                              (NV_DATA & pmsfe_pkg::SFE_NV_MASK); // RL1 RL3
        end

        ////////////////////////////////////////////////////////////////////////////
        // actions on expiry and on the cold-reset pin
        if (SUPERVISOR_EXPIRED && state_reg.ctrl[pmsfe_pkg::SFE_TIMER_BIT]) begin // RL5
            if (state_reg.ctrl[pmsfe_pkg::SFE_EXPIRY_PD_BIT]) begin
                state_next.powerdown_req = 1'b1; // RL6
            end
            if (state_reg.ctrl[pmsfe_pkg::SFE_EXPIRY_RST_BIT]) begin
                state_next.reset_req = 1'b1; // RL7
            end
        end
        // act on the falling edge so a held-low pin asks only once
        if (state_reg.cold_prev && !pins.cold_n && state_reg.ctrl[pmsfe_pkg::SFE_COLD_PD_BIT]) begin
            state_next.powerdown_req = 1'b1; // RL8
        end

        ////////////////////////////////////////////////////////////////////////////
        // serial port
        if (scl_rise) begin
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            state_next.byte_full = (state_reg.bit_cnt == 3'h7);
            if (state_reg.fsm == pmsfe_pkg::PMSFE_ADDR || state_reg.fsm == pmsfe_pkg::PMSFE_PTR ||
                state_reg.fsm == pmsfe_pkg::PMSFE_WDATA) begin
                state_next.shift = {state_reg.shift[6:0], pins.sda};
            end
            if (state_reg.fsm == pmsfe_pkg::PMSFE_RDATA_ACK) begin
                state_next.master_ack = !pins.sda;
            end
        end

        if (start_seen) begin
            // repeated start is taken from any state
            state_next.fsm = pmsfe_pkg::PMSFE_ADDR;
            state_next.bit_cnt = 3'h0;
            state_next.byte_full = 1'b0;
            state_next.sda_oe = 1'b0;
        end else if (stop_seen) begin
            state_next.fsm = pmsfe_pkg::PMSFE_IDLE;
            state_next.sda_oe = 1'b0;
        end else if (scl_fall) begin
            unique case (state_reg.fsm)
                pmsfe_pkg::PMSFE_IDLE: begin
                    state_next.sda_oe = 1'b0;
                end
                pmsfe_pkg::PMSFE_ADDR: begin
                    if (state_reg.byte_full) begin
                        state_next.byte_full = 1'b0;
                        if (state_reg.shift[7:1] == pmsfe_pkg::PMSFE_DEV_ADDR) begin
                            state_next.rw = state_reg.shift[0];
                            state_next.sda_oe = 1'b1;
                            state_next.fsm = pmsfe_pkg::PMSFE_ADDR_ACK;
                        end else begin
                            state_next.fsm = pmsfe_pkg::PMSFE_IDLE;
                        end
                    end
                end
                pmsfe_pkg::PMSFE_ADDR_ACK: begin
                    state_next.bit_cnt = 3'h0;
                    if (state_reg.rw) begin
                        state_next.shift = read_value;
                        state_next.sda_oe = !read_value[7];
                        state_next.fsm = pmsfe_pkg::PMSFE_RDATA;
                    end else begin
                        state_next.sda_oe = 1'b0;
                        state_next.fsm = pmsfe_pkg::PMSFE_PTR;
                    end
                end
                pmsfe_pkg::PMSFE_PTR: begin
                    if (state_reg.byte_full) begin
                        state_next.byte_full = 1'b0;
                        state_next.ptr = state_reg.shift;
                        state_next.sda_oe = 1'b1;
                        state_next.fsm = pmsfe_pkg::PMSFE_PTR_ACK;
                    end
                end
                pmsfe_pkg::PMSFE_PTR_ACK, pmsfe_pkg::PMSFE_WDATA_ACK: begin
                    state_next.bit_cnt = 3'h0;
                    state_next.sda_oe = 1'b0;
                    state_next.fsm = pmsfe_pkg::PMSFE_WDATA;
                end
                pmsfe_pkg::PMSFE_WDATA: begin
                    if (state_reg.byte_full) begin
                        state_next.byte_full = 1'b0;
                        // host write wins over a restore in the same cycle
                        if (state_reg.ptr == pmsfe_pkg::PMSFE_SFE_OFFSET) begin
                            state_next.ctrl = state_reg.shift; // RL9
                        end
                        state_next.sda_oe = 1'b1;
                        state_next.fsm = pmsfe_pkg::PMSFE_WDATA_ACK;
                    end
                end
                pmsfe_pkg::PMSFE_RDATA: begin
                    if (state_reg.byte_full) begin
                        state_next.byte_full = 1'b0;
                        state_next.sda_oe = 1'b0;
                        state_next.fsm = pmsfe_pkg::PMSFE_RDATA_ACK;
                    end else begin
                        state_next.shift = {state_reg.shift[6:0], 1'b0};
                        state_next.sda_oe = !state_reg.shift[6];
                    end
                end
                pmsfe_pkg::PMSFE_RDATA_ACK: begin
                    state_next.bit_cnt = 3'h0;
                    if (state_reg.master_ack) begin
                        state_next.shift = read_value;
                        state_next.sda_oe = !read_value[7];
                        state_next.fsm = pmsfe_pkg::PMSFE_RDATA;
                    end else begin
                        state_next.sda_oe = 1'b0;
                        state_next.fsm = pmsfe_pkg::PMSFE_IDLE;
                    end
                end
                default: begin
                    state_next.sda_oe = 1'b0;
                    state_next.fsm = pmsfe_pkg::PMSFE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= '{
                fsm: pmsfe_pkg::PMSFE_IDLE,
                bit_cnt: 3'h0,
                byte_full: 1'b0,
                shift: 8'h00,
                ptr: 8'h00,
                rw: 1'b0,
                master_ack: 1'b0,
                sda_oe: 1'b0,
                scl_prev: 1'b1,
                sda_prev: 1'b1,
                cold_prev: 1'b1,
                settle: 2'h0,
                ctrl: pmsfe_pkg::SFE_RESET_VALUE,
                powerdown_req: 1'b0,
                reset_req: 1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from state_reg except SDA_OUT, which is tied low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = state_reg.sda_oe;
    assign SLEEP_ENABLE = state_reg.ctrl[pmsfe_pkg::SFE_SLEEP_BIT]; // RL1
    assign RTC_ENABLE = state_reg.ctrl[pmsfe_pkg::SFE_RTC_BIT]; // RL2
    assign BACKUP_CELL_CHARGE_ENABLE = state_reg.ctrl[pmsfe_pkg::SFE_CHARGE_BIT]; // RL3
    assign BACKUP_SUPPLY_COMPARATOR_ENABLE = state_reg.ctrl[pmsfe_pkg::SFE_COMPARATOR_BIT]; // RL4
    assign SUPERVISOR_TIMER_ENABLE = state_reg.ctrl[pmsfe_pkg::SFE_TIMER_BIT]; // RL5
    assign SYSTEM_FUNCTION_ENABLE = state_reg.ctrl;
    assign POWERDOWN_REQ = state_reg.powerdown_req;
    assign RESET_REQ = state_reg.reset_req;

endmodule

// ### test/pmsfe_host_model.sv
/*
 * pmsfe_host_model: two-wire bus master standing in for the host processor.
 * assumes: caller sits on a falling CLK edge; SDA has a pull-up, so released reads 1.
 */
`timescale 1ns/10ps
module pmsfe_host_model (
    // clock
    input wire logic clk,
    // open-drain bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ten cycles per half period keeps well clear of the 4-cycle minimum
    task automatic half();
        repeat (10) @(negedge clk);
    endtask

    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    // data moves a few cycles after the fall so the synced pins never see it with SCL high
    task automatic xbit(input logic b, output logic r);
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask
endmodule

// ### test/pmsfe_top_props.sv
/*
 * pmsfe_top_props: port-level checks of the system function enable block.
 * assumes: bound to pmsfe_top; single CLK domain with RESETN.
 */
`timescale 1ns/10ps
module pmsfe_top_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // causes
    input wire logic COLD_RESET_INPUT_N,
    input wire logic SUPERVISOR_EXPIRED,
    // controls and actions
    input wire logic SLEEP_ENABLE,
    input wire logic RTC_ENABLE,
    input wire logic BACKUP_CELL_CHARGE_ENABLE,
    input wire logic BACKUP_SUPPLY_COMPARATOR_ENABLE,
    input wire logic SUPERVISOR_TIMER_ENABLE,
    input wire logic [7:0] SYSTEM_FUNCTION_ENABLE,
    input wire logic POWERDOWN_REQ,
    input wire logic RESET_REQ,
    // restore and serial port
    input wire logic NV_LOAD,
    input wire logic [7:0] NV_DATA,
    input wire logic SDA_OE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////////
    sleep_mirror_a: assert property (SLEEP_ENABLE == SYSTEM_FUNCTION_ENABLE[7])
        else $error("sleep output differs from bit 7");
    rtc_mirror_a: assert property (RTC_ENABLE == SYSTEM_FUNCTION_ENABLE[6])
        else $error("clock enable differs from bit 6");
    charge_mirror_a: assert property (BACKUP_CELL_CHARGE_ENABLE == SYSTEM_FUNCTION_ENABLE[5])
        else $error("charger enable differs from bit 5");
    comparator_mirror_a: assert property (BACKUP_SUPPLY_COMPARATOR_ENABLE == SYSTEM_FUNCTION_ENABLE[4])
        else $error("comparator enable differs from bit 4");
    timer_gate_a: assert property ((SUPERVISOR_EXPIRED && !SUPERVISOR_TIMER_ENABLE) |=> !RESET_REQ)
        else $error("expiry acted with timer stopped");
    expiry_powerdown_a: assert property ((SUPERVISOR_EXPIRED && SUPERVISOR_TIMER_ENABLE &&
        SYSTEM_FUNCTION_ENABLE[2]) |=> POWERDOWN_REQ ##1 !POWERDOWN_REQ)
        else $error("expiry power-down pulse wrong");
    expiry_reset_a: assert property ((SUPERVISOR_EXPIRED && SUPERVISOR_TIMER_ENABLE) |=>
        (RESET_REQ == $past(SYSTEM_FUNCTION_ENABLE[1])))
        else $error("expiry reset does not follow bit 1");
    reset_cause_a: assert property ($rose(RESET_REQ) |-> $past(SUPERVISOR_EXPIRED))
        else $error("reset request without expiry");
    cold_powerdown_a: assert property (($fell(COLD_RESET_INPUT_N) && SYSTEM_FUNCTION_ENABLE[0])
        |-> ##[1:5] POWERDOWN_REQ)
        else $error("cold pin gave no power-down");
    cold_ignored_a: assert property (($fell(COLD_RESET_INPUT_N) && !SYSTEM_FUNCTION_ENABLE[0]
        && !SUPERVISOR_EXPIRED) |=> !POWERDOWN_REQ [*5])
        else $error("cold pin powered down while disabled");
    // a host write in the same cycle wins; it shows as a rising acknowledge
    restore_keeps_a: assert property (NV_LOAD |=> $rose(SDA_OE) ||
        (SYSTEM_FUNCTION_ENABLE[7] == $past(SYSTEM_FUNCTION_ENABLE[7]) &&
        SYSTEM_FUNCTION_ENABLE[5] == $past(SYSTEM_FUNCTION_ENABLE[5])))
        else $error("restore changed sleep or charger bit");
    restore_loads_a: assert property (NV_LOAD |=> $rose(SDA_OE) ||
        (SYSTEM_FUNCTION_ENABLE[4:0] == $past(NV_DATA[4:0])))
        else $error("restore did not load the low bits");
endmodule

bind pmsfe_top pmsfe_top_props u_props (
    .CLK(CLK), .RESETN(RESETN), .COLD_RESET_INPUT_N(COLD_RESET_INPUT_N),
    .SUPERVISOR_EXPIRED(SUPERVISOR_EXPIRED), .SLEEP_ENABLE(SLEEP_ENABLE), .RTC_ENABLE(RTC_ENABLE),
    .BACKUP_CELL_CHARGE_ENABLE(BACKUP_CELL_CHARGE_ENABLE),
    .BACKUP_SUPPLY_COMPARATOR_ENABLE(BACKUP_SUPPLY_COMPARATOR_ENABLE),
    .SUPERVISOR_TIMER_ENABLE(SUPERVISOR_TIMER_ENABLE), .SYSTEM_FUNCTION_ENABLE(SYSTEM_FUNCTION_ENABLE),
    .POWERDOWN_REQ(POWERDOWN_REQ), .RESET_REQ(RESET_REQ),
    .NV_LOAD(NV_LOAD), .NV_DATA(NV_DATA), .SDA_OE(SDA_OE)
);

// ### test/tb_top.sv
/*
 * tb_top: register accesses over the two-wire port, restore, expiry and cold-pin tests.
 * assumes: pmsfe_host_model as bus master; inputs change on falling CLK edges.
 */
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, host_low, sda_oe, sda_out, sda, ack;
    logic cold_n = 1'b1;
    logic expired = 1'b0;
    logic rtc_kept = 1'b1;
    logic nv_load = 1'b0;
    logic [7:0] nv_data = 8'h00;
    logic sleep_en, rtc_en, charge_en, comp_en, timer_en, pd_req, rst_req;
    logic [7:0] sfe, rdata;
    logic [7:0] cfg [4] = '{8'h0C, 8'h0A, 8'h06, 8'h0E};
    logic [7:0] act [4] = '{8'h02, 8'h01, 8'h00, 8'h03};
    int err_total = 0;
    int checks_done = 0;
    int pulses;
    localparam logic [7:0] OFS = pmsfe_pkg::PMSFE_SFE_OFFSET;

    always #(pmsfe_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    // open drain with pull-up
    assign sda = (sda_oe | host_low) ? 1'b0 : 1'b1;

    pmsfe_top u_dut (
        .CLK(clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .COLD_RESET_INPUT_N(cold_n), .SUPERVISOR_EXPIRED(expired), .RTC_ENABLE_KEPT(rtc_kept),
        .NV_LOAD(nv_load), .NV_DATA(nv_data), .SLEEP_ENABLE(sleep_en), .RTC_ENABLE(rtc_en),
        .BACKUP_CELL_CHARGE_ENABLE(charge_en), .BACKUP_SUPPLY_COMPARATOR_ENABLE(comp_en),
        .SUPERVISOR_TIMER_ENABLE(timer_en), .SYSTEM_FUNCTION_ENABLE(sfe), .POWERDOWN_REQ(pd_req),
        .RESET_REQ(rst_req)
    );
    pmsfe_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR, 1'b0}, ack);
        u_host.put_byte(ptr, ack);
        u_host.put_byte(data, ack);
        u_host.stop();
        repeat (4) @(negedge clk);
    endtask

    // pointer write, repeated start, one byte read closed by a refusal
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR, 1'b0}, ack);
        u_host.put_byte(ptr, ack);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR, 1'b1}, ack);
        u_host.get_byte(1'b1, d);
        u_host.stop();
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // about 26000 cycles expected; the limit leaves ample margin
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        chk(sfe, 8'h40);
        chk({7'h00, sda_out}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(OFS, 8'h01 << i);
            chk({7'h00, ack}, 8'h01);
            chk({sleep_en, rtc_en, charge_en, comp_en, timer_en, 3'h0}, (8'h01 << i) & 8'hF8);
            rd(OFS, rdata);
            chk(rdata, 8'h01 << i);
            wr(OFS, 8'h01 << i);
            chk(sfe, 8'h01 << i);
        end
        $display("test walking bits done");
        wr(8'h11, 8'hAA);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR, 1'b1}, ack);
        u_host.get_byte(1'b1, rdata);
        u_host.stop();
        chk(rdata, pmsfe_pkg::PMSFE_UNMAPPED_READ);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR ^ 7'h01, 1'b0}, ack);
        u_host.stop();
        chk({7'h00, ack}, 8'h00);
        chk(sfe, 8'h80);
        wr(OFS, 8'hA5);
        u_host.start();
        u_host.put_byte({pmsfe_pkg::PMSFE_DEV_ADDR, 1'b1}, ack);
        u_host.get_byte(1'b0, rdata);
        chk(rdata, 8'hA5);
        u_host.get_byte(1'b1, rdata);
        u_host.stop();
        chk(rdata, 8'hA5);
        $display("test refused access done");
        wr(OFS, 8'hFF);
        nv_data = 8'h15;
        nv_load = 1'b1;
        @(negedge clk);
        nv_load = 1'b0;
        @(negedge clk);
        chk(sfe, 8'hF5);
        $display("test restore done");
        for (int i = 0; i < 4; i++) begin
            wr(OFS, cfg[i]);
            expired = 1'b1;
            @(negedge clk);
            expired = 1'b0;
            chk({6'h00, pd_req, rst_req}, act[i]);
            @(negedge clk);
            chk({6'h00, pd_req, rst_req}, 8'h00);
        end
        $display("test expiry done");
        for (int i = 0; i < 2; i++) begin
            wr(OFS, 8'(i));
            pulses = 0;
            cold_n = 1'b0;
            repeat (10) begin
                @(negedge clk);
                pulses += int'(pd_req === 1'b1);
            end
            cold_n = 1'b1;
            repeat (6) @(negedge clk);
            chk(8'(pulses), 8'(i));
        end
        $display("test cold pin done");
        summarize();
    end
endmodule
